/* File: prcp_action_model.sv */
// breaker action unit model: answers each start with a done pulse after a delay, unless an abort or a new start comes first
// assumes start and abort are one-cycle pulses from the command port
`timescale 1ns/100ps
module prcp_action_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic exec_start,
	input wire logic exec_abort,
	input wire logic [7:0] delay,
	input wire logic [7:0] err_val,
	output logic exec_done,
	output logic [7:0] exec_err
);
	logic busy;
	logic [7:0] left;

	// run, count down, drop the action on abort
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			left <= 8'h00;
		end else if (exec_start) begin
			busy <= 1'b1;
			left <= delay;
		end else if (exec_abort) begin
			busy <= 1'b0;
		end else if (busy && left == 8'h00) begin
			busy <= 1'b0;
		end else if (busy) begin
			left <= left - 8'h01;
		end
	end

	// error code valid only with done, garbage otherwise
	assign exec_done = busy && left == 8'h00;
	assign exec_err = exec_done ? err_val : ~err_val;
endmodule : prcp_action_model

/* File: prcp_asserts.sv */
// checker of the command port: register answers and action pulses
// assumes a bind to prcp_top, one clock domain, asynchronous active-low reset
`timescale 1ns/100ps
module prcp_asserts
	import prcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire prcp_req_type req,
	input wire prcp_resp_type resp,
	input wire logic exec_start,
	input wire logic exec_abort
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////
	// request kinds and the refusal answer
	sequence s_bad_rd;
		req.valid && !req.write && (req.addr < 16'h1F40 || req.addr > 16'h1F56);
	endsequence
	sequence s_bad_wr;
		req.valid && req.write && (req.addr < 16'h1F40 || req.addr > 16'h1F53);
	endsequence
	sequence s_good_rd;
		req.valid && !req.write && req.addr >= 16'h1F40 && req.addr <= 16'h1F56;
	endsequence
	sequence s_exc;
		resp.valid && resp.exception && resp.exc_code == 8'h02 && resp.data == 16'h0000;
	endsequence

	////////////////////////////////////////////////////////////////
	a_answer_next: assert property (req.valid |=> resp.valid)
		else $error("no answer one cycle after request");
	a_no_spurious: assert property (!req.valid |=> !resp.valid)
		else $error("answer without request");
	a_bad_read: assert property (s_bad_rd |=> s_exc)
		else $error("unmapped read not refused");
	a_bad_write: assert property (s_bad_wr |=> s_exc)
		else $error("unmapped write not refused");
	a_good_read: assert property (s_good_rd |=> !resp.exception && resp.exc_code == 8'h00)
		else $error("mapped read refused");
	a_write_zero: assert property (req.valid && req.write |=> resp.data == 16'h0000)
		else $error("write answer carries data");
	a_start_pulse: assert property ($rose(exec_start) |=> !exec_start)
		else $error("start longer than one cycle");
	a_abort_pulse: assert property (exec_abort |=> !exec_abort)
		else $error("abort longer than one cycle");
endmodule : prcp_asserts

/* File: prcp_char_check.sv */
// one password character check: digit, upper-case or lower-case Latin letter
// assumes an ASCII character at its input, purely combinational
`timescale 1ns/100ps
module prcp_char_check (
	input wire logic [7:0] ch,
	output logic ok
);

	// accepted ranges, case kept distinct
	assign ok = (ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h41 && ch <= 8'h5A) || (ch >= 8'h61 && ch <= 8'h7A);

endmodule : prcp_char_check

/* File: prcp_consts.svh */
// constants of the protected remote command port: register map, codes, reset values
// assumes inclusion by every design module that needs a figure; the package does not include it
`ifndef PRCP_CONSTS_SVH
`define PRCP_CONSTS_SVH

// register addresses
`define PRCP_ADDR_CMD 16'h1F40
`define PRCP_ADDR_BUF_LAST 16'h1F53
`define PRCP_ADDR_LAST_CMD 16'h1F54
`define PRCP_ADDR_STATUS 16'h1F55
`define PRCP_ADDR_RET_SIZE 16'h1F56
`define PRCP_BUF_WORDS 20

// word index of each field inside the parameter buffer
`define PRCP_IDX_CODE 5'h00
`define PRCP_IDX_LEN 5'h01
`define PRCP_IDX_SEC 5'h03
`define PRCP_IDX_PWD_HI 5'h04
`define PRCP_IDX_PWD_LO 5'h05
`define PRCP_IDX_ARG 5'h06
`define PRCP_IDX_NEWPWD_HI 5'h07
`define PRCP_IDX_NEWPWD_LO 5'h08

// structure limits
`define PRCP_LEN_MIN 16'h000A
`define PRCP_LEN_MAX 16'h001E
`define PRCP_SEC_OPEN 16'h0000
`define PRCP_SEC_PWD 16'h0001

// command codes
`define PRCP_CMD_OPEN_BREAKER 16'h0388
`define PRCP_CMD_SET_PASSWORD 16'h0BB8

// status and error codes
`define PRCP_STATUS_OK 16'h0000
`define PRCP_STATUS_BUSY 16'h0003
`define PRCP_ERR_NONE 8'h00
`define PRCP_ERR_PASSWORD 8'h01
`define PRCP_ERR_ACCESS 8'h02
`define PRCP_ERR_STRUCT 8'h04
`define PRCP_EXC_ILLEGAL_ADDR 8'h02
`define PRCP_MODULE_ADDR 8'h03

// profiles and factory passwords
`define PRCP_PROF_ADMIN 2'h0
`define PRCP_PROF_SERVICES 2'h1
`define PRCP_PROF_ENGINEER 2'h2
`define PRCP_PROF_OPERATOR 2'h3
`define PRCP_PWD_ADMIN 32'h30303030
`define PRCP_PWD_SERVICES 32'h31313131
`define PRCP_PWD_ENGINEER 32'h32323232
`define PRCP_PWD_OPERATOR 32'h33333333

`endif

/* File: prcp_pkg.sv */
// types of the protected remote command port
// assumes the register request port carries one 16-bit register per cycle
package prcp_pkg;

	// one register access of a decoded request
	typedef struct packed {
		logic valid;
		logic write;
		logic last;
		logic [15:0] addr;
		logic [15:0] data;
	} prcp_req_type;

	// answer to one register access
	typedef struct packed {
		logic valid;
		logic exception;
		logic [7:0] exc_code;
		logic [15:0] data;
	} prcp_resp_type;

	// command sequencer states
	typedef enum logic [2:0] {
		PRCP_IDLE = 3'b000,
		PRCP_CHECK = 3'b001,
		PRCP_READ = 3'b010,
		PRCP_CMP = 3'b011,
		PRCP_EXEC = 3'b100,
		PRCP_WAIT = 3'b101
	} prcp_state_type;

endpackage : prcp_pkg

/* File: prcp_pwd_store.sv */
// password memory: one 32-bit word per user profile, registered read data
// assumes one read or one write per cycle from the command sequencer
`timescale 1ns/100ps
`include "prcp_consts.svh"
module prcp_pwd_store (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] rd_idx,
	output logic [31:0] rd_data,
	input wire logic we,
	input wire logic [1:0] wr_idx,
	input wire logic [31:0] wr_data
);

	logic [31:0] mem [0:3];

	// storage with factory contents at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem[`PRCP_PROF_ADMIN] <= `PRCP_PWD_ADMIN;
			mem[`PRCP_PROF_SERVICES] <= `PRCP_PWD_SERVICES;
			mem[`PRCP_PROF_ENGINEER] <= `PRCP_PWD_ENGINEER;
			mem[`PRCP_PROF_OPERATOR] <= `PRCP_PWD_OPERATOR;
		end else if (we) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h00000000;
		end else begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule : prcp_pwd_store

/* File: prcp_tb.sv */
// self-checking bench of the protected remote command port
// assumes design files, checker and action-unit model are compiled first
`timescale 1ns/100ps
module testbench
	import prcp_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	prcp_req_type req = '0;
	prcp_resp_type resp;
	prcp_resp_type rsp;
	logic lock_open = 1'b0;
	logic intrusive_unlocked = 1'b0;
	logic [3:0] intrusive_profile_mask = 4'h0;
	logic exec_done;
	logic exec_start;
	logic exec_abort;
	logic [7:0] exec_err;
	logic [7:0] delay = 8'h02;
	logic [7:0] err_val = 8'h00;
	logic [15:0] exec_code;
	logic [15:0] exec_arg;
	logic [15:0] seen_arg;
	logic [15:0] seen_code;
	int failures = 0;
	int cmp_count = 0;
	int starts = 0;
	int aborts = 0;

	prcp_top prcp_top_inst (.clk(clk), .rst_n(rst_n), .req(req), .resp(resp), .lock_open(lock_open),
		.intrusive_unlocked(intrusive_unlocked), .intrusive_profile_mask(intrusive_profile_mask),
		.exec_done(exec_done), .exec_err(exec_err), .exec_start(exec_start), .exec_abort(exec_abort),
		.exec_code(exec_code), .exec_arg(exec_arg));
	prcp_action_model prcp_action_model_inst (.clk(clk), .rst_n(rst_n), .exec_start(exec_start),
		.exec_abort(exec_abort), .delay(delay), .err_val(err_val), .exec_done(exec_done), .exec_err(exec_err));

	// clock and action counters
	initial forever #2 clk = ~clk;
	always @(posedge clk) begin
		if (exec_start === 1'b1) begin
			starts++;
			seen_arg = exec_arg;
			seen_code = exec_code;
		end
		if (exec_abort === 1'b1)
			aborts++;
	end

	////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (failures == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic lst);
		@(negedge clk);
		req = '{1'b1, wr, lst, a, d};
		@(negedge clk);
		req.valid = 1'b0;
		rsp = resp;
	endtask : acc
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000, 1'b1);
		check(rsp.data, exp);
	endtask : rd
	task automatic cmd(input logic [15:0] code, len, sec, input logic [31:0] pwd, input logic [15:0] arg,
		input logic [31:0] npw);
		logic [15:0] w [9];
		w = '{code, len, 16'h0000, sec, pwd[31:16], pwd[15:0], arg, npw[31:16], npw[15:0]};
		for (int i = 0; i < 9; i++)
			acc(1'b1, 16'h1F40 + 16'(i), w[i], i == 8);
	endtask : cmd
	task automatic fin(input logic [15:0] st, input logic [15:0] code);
		int n;
		n = 0;
		do begin
			acc(1'b0, 16'h1F55, 16'h0000, 1'b1);
			n++;
		end while (rsp.data === 16'h0003 && n < 200);
		check(rsp.data, st);
		rd(16'h1F54, code);
	endtask : fin
	task automatic run(input logic [15:0] code, len, sec, input logic [31:0] pwd, input logic [15:0] arg,
		input logic [31:0] npw, input logic [15:0] st, input int n);
		int s;
		s = starts;
		cmd(code, len, sec, pwd, arg, npw);
		fin(st, code);
		check(16'(starts - s), 16'(n));
	endtask : run

	////////////////////////////////////////////////////////////////
	task automatic t_unmapped;
		logic [16:0] probe [5];
		probe = '{17'h01F3F, 17'h01F57, 17'h11F54, 17'h11F55, 17'h11F56};
		foreach (probe[i]) begin
			acc(probe[i][16], probe[i][15:0], 16'h5A5A, 1'b1);
			check({7'h00, rsp.exception, rsp.exc_code}, 16'h0102);
		end
		acc(1'b1, 16'h1F53, 16'h1234, 1'b1);
		check({7'h00, rsp.exception, rsp.exc_code}, 16'h0000);
	endtask : t_unmapped
	task automatic t_open;
		delay = 8'h14;
		cmd(16'h0388, 16'h0012, 16'h0000, 32'h0, 16'h00A5, 32'h0);
		rd(16'h1F55, 16'h0003);
		fin(16'h0000, 16'h0388);
		check(seen_arg, 16'h00A5);
		check(seen_code, 16'h0388);
		err_val = 8'h05;
		run(16'h0388, 16'h0012, 16'h0000, 32'h0, 16'h0, 32'h0, 16'h0305, 1);
		err_val = 8'h00;
		intrusive_profile_mask = 4'hF;
		run(16'h0388, 16'h0012, 16'h0001, 32'h30303030, 16'h0, 32'h0, 16'h0302, 0);
		lock_open = 1'b1;
		run(16'h0388, 16'h0012, 16'h0001, 32'h30303031, 16'h0, 32'h0, 16'h0301, 0);
	endtask : t_open
	task automatic t_profiles;
		logic [7:0] c;
		for (int p = 0; p < 4; p++) begin
			c = 8'h30 + 8'(p);
			lock_open = p[0];
			intrusive_unlocked = !p[0];
			intrusive_profile_mask = 4'h1 << p;
			run(16'h0388, 16'h0012, 16'h0001, {4{c}}, 16'h0, 32'h0, 16'h0000, 1);
			intrusive_profile_mask = ~(4'h1 << p);
			run(16'h0388, 16'h0012, 16'h0001, {4{c}}, 16'h0, 32'h0, 16'h0301, 0);
		end
	endtask : t_profiles
	task automatic t_struct;
		logic [15:0] lens [4];
		logic ok;
		lens = '{16'h0009, 16'h000A, 16'h001E, 16'h001F};
		lock_open = 1'b0;
		intrusive_unlocked = 1'b0;
		foreach (lens[i]) begin
			ok = i == 1 || i == 2;
			run(16'h0388, lens[i], 16'h0000, 32'h0, 16'h0, 32'h0, ok ? 16'h0000 : 16'h0304, int'(ok));
		end
		run(16'h0388, 16'h0012, 16'h0002, 32'h0, 16'h0, 32'h0, 16'h0304, 0);
	endtask : t_struct
	task automatic t_setpwd;
		lock_open = 1'b1;
		intrusive_profile_mask = 4'hF;
		run(16'h0BB8, 16'h0012, 16'h0001, 32'h30303030, 16'h3, 32'h4162397A, 16'h0000, 0);
		intrusive_profile_mask = 4'h8;
		run(16'h0388, 16'h0012, 16'h0001, 32'h33333333, 16'h0, 32'h0, 16'h0301, 0);
		run(16'h0388, 16'h0012, 16'h0001, 32'h6162397A, 16'h0, 32'h0, 16'h0301, 0);
		run(16'h0388, 16'h0012, 16'h0001, 32'h4162397A, 16'h0, 32'h0, 16'h0000, 1);
		intrusive_profile_mask = 4'hF;
		run(16'h0BB8, 16'h0012, 16'h0001, 32'h4162397A, 16'h3, 32'h33333333, 16'h0000, 0);
		run(16'h0BB8, 16'h0012, 16'h0001, 32'h30303030, 16'h1, 32'h31312131, 16'h0304, 0);
	endtask : t_setpwd
	task automatic t_resend;
		int s;
		int a;
		s = starts;
		a = aborts;
		lock_open = 1'b0;
		delay = 8'h28;
		cmd(16'h0388, 16'h0012, 16'h0000, 32'h0, 16'h0001, 32'h0);
		repeat (4) @(negedge clk);
		cmd(16'h0388, 16'h0012, 16'h0000, 32'h0, 16'h0002, 32'h0);
		fin(16'h0000, 16'h0388);
		check(16'(aborts - a), 16'h0001);
		check(16'(starts - s), 16'h0002);
		check(seen_arg, 16'h0002);
	endtask : t_resend

	////////////////////////////////////////////////////////////////
	// main sequence after reset
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		rd(16'h1F55, 16'h0000);
		rd(16'h1F54, 16'h0000);
		rd(16'h1F56, 16'h0000);
		t_unmapped();
		t_open();
		t_profiles();
		t_struct();
		t_setpwd();
		t_resend();
		wrap_up();
	end

	// watchdog against a hang
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
endmodule : testbench

bind prcp_top prcp_asserts prcp_asserts_inst (.clk(clk), .rst_n(rst_n), .req(req), .resp(resp),
	.exec_start(exec_start), .exec_abort(exec_abort));

/* File: prcp_top.sv */
// protected remote command port: parameter buffer, password and lock gating, status
// assumes a decoded register request stream, one word per cycle, and a breaker
// action unit that answers each started command with a done pulse and an error code
`timescale 1ns/100ps
`include "prcp_consts.svh"
module prcp_top
	import prcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire prcp_req_type req,
	output prcp_resp_type resp,
	input wire logic lock_open,
	input wire logic intrusive_unlocked,
	input wire logic [3:0] intrusive_profile_mask,
	input wire logic exec_done,
	input wire logic [7:0] exec_err,
	output logic exec_start,
	output logic exec_abort,
	output logic [15:0] exec_code,
	output logic [15:0] exec_arg
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [15:0] buf_q [0:`PRCP_BUF_WORDS-1];
	logic in_req;
	logic armed;
	logic [15:0] last_cmd;
	logic [15:0] status;
	prcp_state_type state;
	logic [1:0] idx;
	logic pw_we;
	logic [1:0] pw_wr_idx;
	logic [31:0] pw_wr_data;
	logic [31:0] pw_rd_data;
	logic [3:0] char_ok;
	logic buf_hit;
	logic [4:0] buf_idx;
	logic cmd_hit;
	logic launch;
	logic [31:0] supplied_pwd;
	logic [31:0] new_pwd;
	logic [1:0] target;
	logic is_setpwd;
	logic struct_ok;
	logic [3:0] allowed;
	logic lock_free;
	logic [15:0] rd_word;
	logic rd_ok;
	logic bad_addr;
	logic seq_hold;
	logic chk_step;
	logic sec_open;
	logic chk_bad;
	logic chk_free;
	logic chk_locked;
	logic pw_match;
	logic pw_miss;
	logic pw_set;
	logic go_exec;
	logic exec_busy;
	logic act_done;

	////////////////////////////////////////////////////////////////////////////////
	// address decode and command trigger

	// words 8000 to 8019 live in the parameter buffer
	assign buf_hit = req.addr >= `PRCP_ADDR_CMD && req.addr <= `PRCP_ADDR_BUF_LAST;
	assign buf_idx = 5'(req.addr - `PRCP_ADDR_CMD);

	// first word of a write request lands on the code register
	assign cmd_hit = req.valid && req.write && !in_req && req.addr == `PRCP_ADDR_CMD;
	// the buffer is complete at the last word of that request
	assign launch = req.valid && req.write && req.last && (cmd_hit || armed);

	// request framing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_req <= 1'b0;
			armed <= 1'b0;
		end else if (req.valid) begin
			in_req <= !req.last;
			armed <= (cmd_hit || armed) && !req.last;
		end
	end

	// parameter buffer storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `PRCP_BUF_WORDS; i++) begin
				buf_q[i] <= 16'h0000;
			end
		end else if (req.valid && req.write && buf_hit) begin
			buf_q[buf_idx] <= req.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read and answer

	// read mux over the implemented words
	always_comb begin
		rd_word = 16'h0000;
		rd_ok = 1'b1;
		if (buf_hit) begin
			rd_word = buf_q[buf_idx];
		end else if (req.addr == `PRCP_ADDR_LAST_CMD) begin
			rd_word = last_cmd;
		end else if (req.addr == `PRCP_ADDR_STATUS) begin
			rd_word = status;
		end else if (req.addr == `PRCP_ADDR_RET_SIZE) begin
			rd_word = 16'h0000;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// unmapped word, or a write outside the parameter buffer
	assign bad_addr = req.write ? !buf_hit : !rd_ok;

	// one answer per access, result words are read-only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resp <= '0;
		end else begin
			resp.valid <= req.valid;
			resp.exception <= req.valid && bad_addr;
			resp.exc_code <= (req.valid && bad_addr) ? `PRCP_EXC_ILLEGAL_ADDR : 8'h00;
			resp.data <= (req.valid && !req.write) ? rd_word : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode

	assign supplied_pwd = {buf_q[`PRCP_IDX_PWD_HI], buf_q[`PRCP_IDX_PWD_LO]};
	assign new_pwd = {buf_q[`PRCP_IDX_NEWPWD_HI], buf_q[`PRCP_IDX_NEWPWD_LO]};
	assign target = buf_q[`PRCP_IDX_ARG][1:0];
	assign is_setpwd = buf_q[`PRCP_IDX_CODE] == `PRCP_CMD_SET_PASSWORD;

	// new password characters
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_chars
			prcp_char_check u_char (
				.ch(new_pwd[8*g +: 8]),
				.ok(char_ok[g])
			);
		end
	endgenerate

	// buffer structure and password format
	assign struct_ok = buf_q[`PRCP_IDX_LEN] >= `PRCP_LEN_MIN && buf_q[`PRCP_IDX_LEN] <= `PRCP_LEN_MAX
		&& (buf_q[`PRCP_IDX_SEC] == `PRCP_SEC_OPEN || buf_q[`PRCP_IDX_SEC] == `PRCP_SEC_PWD)
		&& (!is_setpwd || (buf_q[`PRCP_IDX_SEC] == `PRCP_SEC_PWD && buf_q[`PRCP_IDX_ARG][15:2] == 14'h0000
		&& char_ok == 4'hF));

	// profiles whose password unlocks this command; administrator always for a change
	assign allowed = is_setpwd ? (4'h1 | (4'h1 << target)) : intrusive_profile_mask;

	assign lock_free = lock_open || intrusive_unlocked;

	////////////////////////////////////////////////////////////////////////////////
	// command sequencer

	// step decisions, only while no request word overrides the sequence
	assign seq_hold = !cmd_hit && !launch;
	assign chk_step = seq_hold && state == PRCP_CHECK;
	assign sec_open = buf_q[`PRCP_IDX_SEC] == `PRCP_SEC_OPEN;
	assign chk_bad = chk_step && !struct_ok;
	assign chk_free = chk_step && struct_ok && sec_open;
	// lock is judged before any password
	assign chk_locked = chk_step && struct_ok && !sec_open && !lock_free;
	// exact 32-bit compare keeps case distinct
	assign pw_match = seq_hold && state == PRCP_CMP && pw_rd_data == supplied_pwd && allowed[idx];
	assign pw_miss = seq_hold && state == PRCP_CMP && !pw_match && idx == `PRCP_PROF_OPERATOR;
	assign pw_set = pw_match && is_setpwd;
	assign go_exec = chk_free || (pw_match && !is_setpwd);
	assign exec_busy = state == PRCP_EXEC || state == PRCP_WAIT;
	assign act_done = seq_hold && state == PRCP_WAIT && exec_done;

	// step through check, password scan, action and wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PRCP_IDLE;
			idx <= 2'h0;
		end else if (cmd_hit) begin
			state <= launch ? PRCP_CHECK : PRCP_IDLE;
		end else if (launch) begin
			state <= PRCP_CHECK;
		end else begin
			unique case (state)
				PRCP_IDLE: begin
					state <= PRCP_IDLE;
				end
				PRCP_CHECK: begin
					idx <= 2'h0;
					if (chk_bad || chk_locked) begin
						state <= PRCP_IDLE;
					end else if (chk_free) begin
						state <= PRCP_EXEC;
					end else begin
						state <= PRCP_READ;
					end
				end
				PRCP_READ: begin
					state <= PRCP_CMP;
				end
				PRCP_CMP: begin
					if (pw_match) begin
						state <= is_setpwd ? PRCP_IDLE : PRCP_EXEC;
					end else if (pw_miss) begin
						state <= PRCP_IDLE;
					end else begin
						idx <= idx + 2'h1;
						state <= PRCP_READ;
					end
				end
				PRCP_EXEC: begin
					state <= PRCP_WAIT;
				end
				PRCP_WAIT: begin
					state <= act_done ? PRCP_IDLE : PRCP_WAIT;
				end
				default: begin
					state <= PRCP_IDLE;
				end
			endcase
		end
	end

	// completion code and code of the last command, refused or executed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= `PRCP_STATUS_OK;
			last_cmd <= 16'h0000;
		end else if (cmd_hit) begin
			status <= `PRCP_STATUS_BUSY;
		end else if (chk_bad) begin
			status <= {`PRCP_MODULE_ADDR, `PRCP_ERR_STRUCT};
			last_cmd <= buf_q[`PRCP_IDX_CODE];
		end else if (chk_locked) begin
			status <= {`PRCP_MODULE_ADDR, `PRCP_ERR_ACCESS};
			last_cmd <= buf_q[`PRCP_IDX_CODE];
		end else if (pw_set) begin
			status <= `PRCP_STATUS_OK;
			last_cmd <= buf_q[`PRCP_IDX_CODE];
		end else if (pw_miss) begin
			status <= {`PRCP_MODULE_ADDR, `PRCP_ERR_PASSWORD};
			last_cmd <= buf_q[`PRCP_IDX_CODE];
		end else if (act_done) begin
			status <= exec_err == `PRCP_ERR_NONE ? `PRCP_STATUS_OK
				: {`PRCP_MODULE_ADDR, exec_err};
			last_cmd <= exec_code;
		end
	end

	// action start and abort pulses, a new command drops whatever runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_start <= 1'b0;
			exec_abort <= 1'b0;
			exec_code <= 16'h0000;
			exec_arg <= 16'h0000;
		end else begin
			exec_start <= go_exec;
			exec_abort <= cmd_hit && exec_busy;
			if (go_exec) begin
				exec_code <= buf_q[`PRCP_IDX_CODE];
				exec_arg <= buf_q[`PRCP_IDX_ARG];
			end
		end
	end

	// password change once the presented password matched
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pw_we <= 1'b0;
			pw_wr_idx <= 2'h0;
			pw_wr_data <= 32'h00000000;
		end else begin
			pw_we <= pw_set;
			if (pw_set) begin
				pw_wr_idx <= target;
				pw_wr_data <= new_pwd;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// password memory

	prcp_pwd_store u_store (
		.clk(clk),
		.rst_n(rst_n),
		.rd_idx(idx),
		.rd_data(pw_rd_data),
		.we(pw_we),
		.wr_idx(pw_wr_idx),
		.wr_data(pw_wr_data)
	);

endmodule : prcp_top
